// File: pkg/bkcmp_pkg.sv
// What this block does
// R1 - qualifier 0 off, 1 any memory cycle
// R2 - qualifier 2 takes reads and fetches
// R3 - qualifier 3 takes memory writes only
// R4 - qualifier 4 takes instruction fetches only
// R5 - no range: match either address exactly
// R6 - range, second not below: inclusive span
// R7 - second below first: outside span only
// R8 - exclusion decided before address masking
// R9 - address mask ones enable, reset all ones
// R10 - event count register 0 to 7fff
// R11 - delay counts after events reach zero
// R12 - delay decrements once per trace sample
// R13 - event when all criteria match
// R14 - halt when counts and delay done
// R15 - run reloads settings, clears history
// R16 - step keeps history unless counts rewritten
// R17 - step loads changed non-count settings
// R18 - serial i/o cycles also breakable
// R19 - memory data compare, mask reset zero
// R20 - eight probes compared under mask
// R21 - probe byte and mask reset zero
// R22 - event is and of probe match with memory or i/o match
// R23 - evaluation one clock after condition
// R24 - halt only at instruction boundary
// R25 - event count decrements to zero, triggers
package bkcmp_pkg;
  localparam int APB_AW = 8;
  localparam int EVT_W  = 15;
  localparam int DLY_W  = 11;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MADR1  = 8'h04;
  localparam logic [7:0] OFS_MADR2  = 8'h08;
  localparam logic [7:0] OFS_IADR1  = 8'h0C;
  localparam logic [7:0] OFS_IADR2  = 8'h10;
  localparam logic [7:0] OFS_AMASK  = 8'h14;
  localparam logic [7:0] OFS_DWORD  = 8'h18;
  localparam logic [7:0] OFS_DMASK  = 8'h1C;
  localparam logic [7:0] OFS_EXT    = 8'h20;
  localparam logic [7:0] OFS_EVTCNT = 8'h24;
  localparam logic [7:0] OFS_DLYCNT = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  // reset values
  localparam logic [15:0] AMASK_RST = 16'hFFFF;
  localparam logic [15:0] DMASK_RST = 16'h0000;
  localparam logic [7:0]  EXT_RST   = 8'h00;
  // memory qualifier codes
  localparam logic [2:0] Q_OFF   = 3'h0;
  localparam logic [2:0] Q_ANY   = 3'h1;
  localparam logic [2:0] Q_RDFE  = 3'h2;
  localparam logic [2:0] Q_WR    = 3'h3;
  localparam logic [2:0] Q_FETCH = 3'h4;
  typedef enum logic [2:0] {
    PH_IDLE, PH_COUNT, PH_DELAY, PH_WAIT, PH_HALTED
  } bkcmp_phase_t;
  typedef struct packed {
    logic [2:0]  mq;
    logic        mr;
    logic        iq;
    logic        ir;
    logic [15:0] ma1;
    logic [15:0] ma2;
    logic [15:0] ia1;
    logic [15:0] ia2;
    logic [15:0] am;
    logic [15:0] dw;
    logic [15:0] dm;
    logic [7:0]  eb;
    logic [7:0]  em;
  } bkcmp_cfg_t;
endpackage

// File: logic/bkcmp_top.sv
`timescale 1ns/10ps
module bkcmp_top (
  // clock and reset
  input  wire logic                            mclk,
  input  wire logic                            sys_rst,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [bkcmp_pkg::APB_AW-1:0]    paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // observed processor cycle
  input  wire logic                            cyc_valid,
  input  wire logic                            cyc_mem_rd,
  input  wire logic                            cyc_mem_wr,
  input  wire logic                            cyc_fetch,
  input  wire logic                            cyc_io_rd,
  input  wire logic                            cyc_io_wr,
  input  wire logic [15:0]                     cyc_addr,
  input  wire logic [15:0]                     cyc_data,
  input  wire logic [7:0]                      probe_in,
  // trace and monitor control
  input  wire logic                            sample_strobe,
  input  wire logic                            instr_boundary,
  input  wire logic                            run_cmd,
  input  wire logic                            step_cmd,
  // results
  output logic                                 halt_req,
  output logic                                 break_event
);
  import bkcmp_pkg::*;

  typedef struct packed {
    bkcmp_cfg_t       cfg;
    bkcmp_cfg_t       act;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt;
    logic [DLY_W-1:0] dly_set;
    logic [DLY_W-1:0] dly;
    logic             dirty;
    bkcmp_phase_t     ph;
    logic [7:0]       p1;
    logic [7:0]       p2;
    logic             hit;
    logic             halt;
    logic             evp;
    logic             rdy;
    logic             err;
    logic [31:0]      rdata;
  } bkcmp_st_t;

  bkcmp_st_t s_q;
  bkcmp_st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // comparison helpers

  // equality on the bits a one in the mask enables
  function automatic logic meq16(input logic [15:0] a, input logic [15:0] b,
                                 input logic [15:0] m);
    meq16 = ((a ^ b) & m) == 16'h0000;
  endfunction

  // address qualification: points, inclusive or exclusive span
  function automatic logic addr_ok(input logic [15:0] a,
                                   input logic [15:0] a1,
                                   input logic [15:0] a2,
                                   input logic rng, input logic [15:0] m);
    logic [15:0] x;
    x = a & m;
    if (!rng) begin
      addr_ok = meq16(a, a1, m) || meq16(a, a2, m); // [R5] [R9]
    end else if (a2 >= a1) begin
      addr_ok = (x >= (a1 & m)) && (x <= (a2 & m)); // [R6] [R9]
    end else begin
      // exclusion is judged on the raw address; the mask term is always true here
      addr_ok = ((a < a2) || (a > a1)) && meq16(a, a, m); // [R7] [R8]
    end
  endfunction

  // memory cycle type qualifier
  function automatic logic mq_ok(input logic [2:0] q, input logic rd,
                                 input logic wr, input logic fe);
    case (q)
      Q_ANY:   mq_ok = rd | wr | fe; // [R1]
      Q_RDFE:  mq_ok = rd | fe;      // [R2]
      Q_WR:    mq_ok = wr;           // [R3]
      Q_FETCH: mq_ok = fe;           // [R4]
      default: mq_ok = 1'b0;         // [R1]
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic        acc;
  logic        wr_en;
  logic        cnt_wr;
  logic        mapped;
  logic        mem_hit;
  logic        io_hit;
  logic        ext_ok;
  logic [31:0] rd_val;

  always_comb begin
    s_d     = s_q;
    acc     = psel && penable;
    wr_en   = acc && pwrite && s_q.rdy;
    cnt_wr  = wr_en && (paddr == OFS_EVTCNT || paddr == OFS_DLYCNT);
    mapped  = 1'b1;
    rd_val  = 32'h0000_0000;
    // register read mux
    case (paddr)
      OFS_CTRL:   rd_val = {26'h000_0000, s_q.cfg.ir, s_q.cfg.iq,
                            s_q.cfg.mr, s_q.cfg.mq};
      OFS_MADR1:  rd_val = {16'h0000, s_q.cfg.ma1};
      OFS_MADR2:  rd_val = {16'h0000, s_q.cfg.ma2};
      OFS_IADR1:  rd_val = {16'h0000, s_q.cfg.ia1};
      OFS_IADR2:  rd_val = {16'h0000, s_q.cfg.ia2};
      OFS_AMASK:  rd_val = {16'h0000, s_q.cfg.am};
      OFS_DWORD:  rd_val = {16'h0000, s_q.cfg.dw};
      OFS_DMASK:  rd_val = {16'h0000, s_q.cfg.dm};
      OFS_EXT:    rd_val = {16'h0000, s_q.cfg.em, s_q.cfg.eb};
      OFS_EVTCNT: rd_val = {17'h0_0000, s_q.evt_set};
      OFS_DLYCNT: rd_val = {21'h00_0000, s_q.dly_set};
      OFS_STATUS: rd_val = {s_q.halt, s_q.dirty, s_q.ph,
                            s_q.dly, 1'b0, s_q.evt};
      default:    mapped = 1'b0;
    endcase
    // apb answer one cycle into the access phase
    s_d.rdy   = acc && !s_q.rdy;
    s_d.err   = acc && !s_q.rdy && !mapped;
    s_d.rdata = (acc && !s_q.rdy && !pwrite) ? rd_val : 32'h0000_0000;
    // register writes land at the edge where pready is seen high
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          s_d.cfg.mq = pwdata[2:0];
          s_d.cfg.mr = pwdata[3];
          s_d.cfg.iq = pwdata[4]; // [R18]
          s_d.cfg.ir = pwdata[5];
        end
        OFS_MADR1:  s_d.cfg.ma1 = pwdata[15:0];
        OFS_MADR2:  s_d.cfg.ma2 = pwdata[15:0];
        OFS_IADR1:  s_d.cfg.ia1 = pwdata[15:0];
        OFS_IADR2:  s_d.cfg.ia2 = pwdata[15:0];
        OFS_AMASK:  s_d.cfg.am  = pwdata[15:0];
        OFS_DWORD:  s_d.cfg.dw  = pwdata[15:0];
        OFS_DMASK:  s_d.cfg.dm  = pwdata[15:0];
        OFS_EXT: begin
          s_d.cfg.eb = pwdata[7:0];
          s_d.cfg.em = pwdata[15:8];
        end
        OFS_EVTCNT: begin
          s_d.evt_set = pwdata[EVT_W-1:0]; // [R10]
          s_d.dirty   = 1'b1;              // [R16]
        end
        OFS_DLYCNT: begin
          s_d.dly_set = pwdata[DLY_W-1:0]; // [R11]
          s_d.dirty   = 1'b1;              // [R16]
        end
        default: ;
      endcase
    end
    // probe synchroniser
    s_d.p1 = probe_in;
    s_d.p2 = s_q.p1;
    // cycle match, registered so it is judged one clock later
    ext_ok  = ((s_q.p2 ^ s_q.act.eb) & s_q.act.em) == 8'h00; // [R20]
    mem_hit = mq_ok(s_q.act.mq, cyc_mem_rd, cyc_mem_wr, cyc_fetch)
              && addr_ok(cyc_addr, s_q.act.ma1, s_q.act.ma2,
                         s_q.act.mr, s_q.act.am)
              && meq16(cyc_data, s_q.act.dw, s_q.act.dm); // [R19]
    io_hit  = s_q.act.iq && (cyc_io_rd || cyc_io_wr)
              && addr_ok(cyc_addr, s_q.act.ia1, s_q.act.ia2,
                         s_q.act.ir, s_q.act.am); // [R18]
    s_d.hit = cyc_valid && ext_ok && (mem_hit || io_hit); // [R22] [R23]
    s_d.evp = 1'b0;
    // event, delay and halt sequencing
    case (s_q.ph)
      PH_COUNT: begin
        if (s_q.hit) begin
          s_d.evp = 1'b1; // [R13]
          if (s_q.evt <= 15'h0001) begin
            s_d.evt = 15'h0000; // [R25]
            s_d.ph  = (s_q.dly == 11'h000) ? PH_WAIT : PH_DELAY;
          end else begin
            s_d.evt = s_q.evt - 15'h0001; // [R25]
          end
        end
      end
      PH_DELAY: begin
        if (sample_strobe) begin
          if (s_q.dly <= 11'h001) begin
            s_d.dly = 11'h000; // [R11]
            s_d.ph  = PH_WAIT;
          end else begin
            s_d.dly = s_q.dly - 11'h001; // [R12]
          end
        end
      end
      PH_WAIT: begin
        if (instr_boundary) begin
          s_d.ph   = PH_HALTED; // [R24]
          s_d.halt = 1'b1;      // [R14]
        end
      end
      PH_IDLE, PH_HALTED: ;
      default: s_d.ph = PH_IDLE;
    endcase
    // run command: reload everything, drop history
    if (run_cmd) begin
      s_d.act   = s_q.cfg; // [R15]
      s_d.evt   = s_q.evt_set;
      s_d.dly   = s_q.dly_set;
      s_d.dirty = cnt_wr; // [R16] a count written now still waits
      s_d.ph    = PH_COUNT;
      s_d.halt  = 1'b0;
      s_d.hit   = 1'b0;
    end else if (step_cmd) begin
      s_d.act   = s_q.cfg; // [R17]
      s_d.dirty = cnt_wr;  // [R16] set wins over the clear
      s_d.halt  = 1'b0;
      s_d.hit   = 1'b0;
      if (s_q.dirty) begin
        s_d.evt = s_q.evt_set;
        s_d.dly = s_q.dly_set;
        s_d.ph  = PH_COUNT;
      end else if (s_q.ph == PH_HALTED || s_q.ph == PH_IDLE) begin
        s_d.ph = PH_COUNT; // [R16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q        <= '0;
      s_q.cfg.am <= AMASK_RST; // [R9]
      s_q.act.am <= AMASK_RST;
      s_q.cfg.dm <= DMASK_RST; // [R19]
      s_q.act.dm <= DMASK_RST;
      s_q.cfg.eb <= EXT_RST;   // [R21]
      s_q.cfg.em <= EXT_RST;
      s_q.act.eb <= EXT_RST;
      s_q.act.em <= EXT_RST;
      s_q.ph     <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign prdata      = s_q.rdata;
  assign pready      = s_q.rdy;
  assign pslverr     = s_q.err;
  assign halt_req    = s_q.halt;
  assign break_event = s_q.evp;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_qual_off: assert property ( // [R1]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.act.mq == Q_OFF && !s_q.act.iq) |=> !s_q.hit)
    else $error("hit with all qualifiers off");

  chk_write_only: assert property ( // [R3]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.act.mq == Q_WR && !s_q.act.iq && !cyc_mem_wr) |=> !s_q.hit)
    else $error("write qualifier hit on non-write");

  chk_fetch_only: assert property ( // [R4]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.act.mq == Q_FETCH && !s_q.act.iq && !cyc_fetch) |=> !s_q.hit)
    else $error("fetch qualifier hit on non-fetch");

  chk_hit_latency: assert property ( // [R23]
    @(posedge mclk) disable iff (sys_rst)
    (cyc_valid && cyc_mem_rd && s_q.act.mq == Q_ANY && !s_q.act.mr
     && cyc_addr == s_q.act.ma1 && s_q.act.dm == 16'h0000
     && s_q.act.em == 8'h00 && !run_cmd && !step_cmd) |=> s_q.hit)
    else $error("matching read not seen one clock later");

  chk_evt_dec: assert property ( // [R25]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.ph == PH_COUNT && s_q.hit && s_q.evt > 15'h0001
     && !run_cmd && !step_cmd) |=> (s_q.evt == $past(s_q.evt) - 15'h0001))
    else $error("event count did not step down");

  chk_delay_dec: assert property ( // [R12]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.ph == PH_DELAY && sample_strobe && s_q.dly > 11'h001
     && !run_cmd && !step_cmd) |=> (s_q.dly == $past(s_q.dly) - 11'h001))
    else $error("delay count did not step down on sample");

  chk_halt_boundary: assert property ( // [R24]
    @(posedge mclk) disable iff (sys_rst)
    $rose(s_q.halt) |-> ($past(instr_boundary) && $past(s_q.ph) == PH_WAIT))
    else $error("halt raised off an instruction boundary");

  chk_run_reload: assert property ( // [R15]
    @(posedge mclk) disable iff (sys_rst)
    run_cmd |=> (s_q.evt == $past(s_q.evt_set)
                 && s_q.dly == $past(s_q.dly_set) && !s_q.halt
                 && s_q.ph == PH_COUNT))
    else $error("run did not reload counts");

  chk_step_keep: assert property ( // [R16]
    @(posedge mclk) disable iff (sys_rst)
    (step_cmd && !run_cmd && !s_q.dirty) |=> (s_q.evt == $past(s_q.evt)))
    else $error("step lost event history");

  chk_read_fetch: assert property ( // [R2]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.act.mq == Q_RDFE && !s_q.act.iq && !cyc_mem_rd && !cyc_fetch)
    |=> !s_q.hit)
    else $error("read qualifier hit on a write");

  chk_delay_idle: assert property ( // [R11]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.ph == PH_COUNT && !run_cmd && !step_cmd) |=> $stable(s_q.dly))
    else $error("delay moved before events ran out");

  chk_event_pulse: assert property ( // [R13]
    @(posedge mclk) disable iff (sys_rst)
    s_q.evp |-> ($past(s_q.hit) && $past(s_q.ph) == PH_COUNT))
    else $error("event pulse without a counted hit");

  chk_probe_block: assert property ( // [R20]
    @(posedge mclk) disable iff (sys_rst)
    (((s_q.p2 ^ s_q.act.eb) & s_q.act.em) != 8'h00) |=> !s_q.hit)
    else $error("hit while probes disagree");

  chk_data_block: assert property ( // [R19]
    @(posedge mclk) disable iff (sys_rst)
    (!s_q.act.iq && ((cyc_data ^ s_q.act.dw) & s_q.act.dm) != 16'h0000)
    |=> !s_q.hit)
    else $error("hit while data word disagrees");

  chk_halt_hold: assert property ( // [R14]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.halt && !run_cmd && !step_cmd) |=> s_q.halt)
    else $error("halt dropped without a command");

  chk_last_event: assert property ( // [R25]
    @(posedge mclk) disable iff (sys_rst)
    (s_q.ph == PH_COUNT && s_q.hit && s_q.evt <= 15'h0001
     && !run_cmd && !step_cmd)
    |=> (s_q.evt == 15'h0000 && s_q.ph != PH_COUNT))
    else $error("last event did not end counting");

endmodule // bkcmp_top

// File: verification/bkcmp_proc_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// emulated processor bus cycles and monitor control pulses
module bkcmp_proc_model (
  // requests from the bench
  input  wire logic        bus_on,
  input  wire logic [2:0]  bus_kind,
  input  wire logic [15:0] bus_a,
  input  wire logic [15:0] bus_d,
  input  wire logic [7:0]  probe_v,
  input  wire logic        pulse_on,
  input  wire logic [1:0]  pulse_sel,
  // processor bus cycle
  output logic             cyc_valid,
  output logic             cyc_mem_rd,
  output logic             cyc_mem_wr,
  output logic             cyc_fetch,
  output logic             cyc_io_rd,
  output logic             cyc_io_wr,
  output logic [15:0]      cyc_addr,
  output logic [15:0]      cyc_data,
  output logic [7:0]       probe_in,
  // monitor and trace pulses
  output logic             sample_strobe,
  output logic             instr_boundary,
  output logic             run_cmd,
  output logic             step_cmd
);
  // one-hot cycle type while a cycle is on the bus
  assign cyc_valid = bus_on;
  assign {cyc_io_wr, cyc_io_rd, cyc_fetch, cyc_mem_wr, cyc_mem_rd} =
    bus_on ? (5'h01 << bus_kind) : 5'h00;
  // an idle bus shows the inverse of the last cycle
  assign cyc_addr = bus_on ? bus_a : ~bus_a;
  assign cyc_data = bus_on ? bus_d : ~bus_d;
  // probe levels stay until changed
  assign probe_in = probe_v;
  // one-hot pulse: 0 run, 1 step, 2 trace sample, 3 boundary
  assign {instr_boundary, sample_strobe, step_cmd, run_cmd} =
    pulse_on ? (4'h1 << pulse_sel) : 4'h0;
endmodule // bkcmp_proc_model

// File: verification/tb_breakpoint_event_comparator.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module tb_breakpoint_event_comparator;
  import bkcmp_pkg::*;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [15:0] am;
    logic [2:0]  kind;
    logic [15:0] adr;
    logic        ev;
  } bkcmp_row_t;
  localparam int NROW  = 22;
  localparam int LIMIT = 6000;
  logic              mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdata;
  logic              rerr, cyc_valid, cyc_mem_rd, cyc_mem_wr, cyc_fetch;
  logic              cyc_io_rd, cyc_io_wr, sample_strobe, instr_boundary;
  logic              run_cmd, step_cmd, halt_req, break_event;
  logic [15:0]       cyc_addr, cyc_data;
  logic [7:0]        probe_in;
  // requests to the processor model
  logic              bus_on, pulse_on;
  logic [2:0]        bus_kind;
  logic [1:0]        pulse_sel;
  logic [15:0]       bus_a, bus_d;
  logic [7:0]        probe_v;
  int                err_count, n_checks, cyc_n;
  // ctl, addr1, addr2, mask, kind, cycle address, event expected
  bkcmp_row_t rows [NROW] = '{
    '{8'h00, 16'h1234, 16'h5678, 16'hFFFF, 3'h0, 16'h1234, 1'b0},
    '{8'h01, 16'h1234, 16'h5678, 16'hFFFF, 3'h1, 16'h1234, 1'b1},
    '{8'h01, 16'h1234, 16'h5678, 16'hFFFF, 3'h2, 16'h1234, 1'b1},
    '{8'h02, 16'h1234, 16'h5678, 16'hFFFF, 3'h0, 16'h1234, 1'b1},
    '{8'h02, 16'h1234, 16'h5678, 16'hFFFF, 3'h1, 16'h1234, 1'b0},
    '{8'h02, 16'h1234, 16'h5678, 16'hFFFF, 3'h2, 16'h1234, 1'b1},
    '{8'h03, 16'h1234, 16'h5678, 16'hFFFF, 3'h1, 16'h1234, 1'b1},
    '{8'h03, 16'h1234, 16'h5678, 16'hFFFF, 3'h2, 16'h1234, 1'b0},
    '{8'h04, 16'h1234, 16'h5678, 16'hFFFF, 3'h2, 16'h1234, 1'b1},
    '{8'h04, 16'h1234, 16'h5678, 16'hFFFF, 3'h0, 16'h1234, 1'b0},
    '{8'h10, 16'h1234, 16'h5678, 16'hFFFF, 3'h3, 16'h0000, 1'b1},
    '{8'h10, 16'h1234, 16'h5678, 16'hFFFF, 3'h4, 16'h0000, 1'b1},
    '{8'h04, 16'h1234, 16'h5678, 16'hFFFF, 3'h3, 16'h0000, 1'b0},
    '{8'h01, 16'h1234, 16'h5678, 16'hFFFF, 3'h0, 16'h5678, 1'b1},
    '{8'h01, 16'h1234, 16'h5678, 16'hFFFF, 3'h0, 16'h1235, 1'b0},
    '{8'h09, 16'h1000, 16'h2000, 16'hFFFF, 3'h0, 16'h2000, 1'b1},
    '{8'h09, 16'h1000, 16'h2000, 16'hFFFF, 3'h0, 16'h2001, 1'b0},
    '{8'h09, 16'h2000, 16'h1000, 16'hFFFF, 3'h0, 16'h1000, 1'b0},
    '{8'h09, 16'h2000, 16'h1000, 16'hFFFF, 3'h0, 16'h2001, 1'b1},
    '{8'h09, 16'h2000, 16'h1000, 16'h0000, 3'h0, 16'h1800, 1'b0},
    '{8'h09, 16'h2000, 16'h1000, 16'h0000, 3'h0, 16'h3000, 1'b1},
    '{8'h01, 16'h1200, 16'h5678, 16'hFF00, 3'h0, 16'h12AB, 1'b1}
  };
  bkcmp_top u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cyc_valid(cyc_valid),
    .cyc_mem_rd(cyc_mem_rd), .cyc_mem_wr(cyc_mem_wr),
    .cyc_fetch(cyc_fetch), .cyc_io_rd(cyc_io_rd), .cyc_io_wr(cyc_io_wr),
    .cyc_addr(cyc_addr), .cyc_data(cyc_data), .probe_in(probe_in),
    .sample_strobe(sample_strobe), .instr_boundary(instr_boundary),
    .run_cmd(run_cmd), .step_cmd(step_cmd), .halt_req(halt_req),
    .break_event(break_event)
  );
  bkcmp_proc_model u_proc (
    .bus_on(bus_on), .bus_kind(bus_kind), .bus_a(bus_a), .bus_d(bus_d),
    .probe_v(probe_v), .pulse_on(pulse_on), .pulse_sel(pulse_sel),
    .cyc_valid(cyc_valid), .cyc_mem_rd(cyc_mem_rd),
    .cyc_mem_wr(cyc_mem_wr), .cyc_fetch(cyc_fetch),
    .cyc_io_rd(cyc_io_rd), .cyc_io_wr(cyc_io_wr), .cyc_addr(cyc_addr),
    .cyc_data(cyc_data), .probe_in(probe_in),
    .sample_strobe(sample_strobe), .instr_boundary(instr_boundary),
    .run_cmd(run_cmd), .step_cmd(step_cmd)
  );
  ////////////////////////////////////////////////////////////////
  // counts, verdict and hang guard
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      err_count++;
      stop_test();
    end
  end
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; a clock passes after release
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // one cycle: 0 rd, 1 wr, 2 fetch, 3 io rd, 4 io wr
  task automatic bus(input int kind, input logic [15:0] a,
                     input logic [15:0] d);
    bus_on   <= 1'b1;
    bus_kind <= kind[2:0];
    bus_a    <= a;
    bus_d    <= d;
    @(posedge mclk);
    bus_on   <= 1'b0;
  endtask
  // one-clock pulse: 0 run, 1 step, 2 trace sample, 3 boundary
  task automatic pulse(input int which);
    pulse_on  <= 1'b1;
    pulse_sel <= which[1:0];
    @(posedge mclk);
    pulse_on  <= 1'b0;
  endtask
  // one bus cycle, event looked at two clocks after it is taken
  task automatic ev(input int k, input logic [15:0] a,
                    input logic [15:0] d, input logic want);
    bus(k, a, d);
    repeat (2) @(posedge mclk);
    chk({31'h0, break_event}, {31'h0, want});
  endtask
  // halt level one clock later
  task automatic halt_is(input logic want);
    @(posedge mclk);
    chk({31'h0, halt_req}, {31'h0, want});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, n_checks, cyc_n} = '0;
    {bus_on, pulse_on, bus_kind, pulse_sel, bus_a, bus_d, probe_v} = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    // table of qualifier and address cases, fresh run per row
    for (int i = 0; i < NROW; i++) begin
      apb(1'b1, OFS_CTRL, {24'h00_0000, rows[i].ctl});
      apb(1'b1, OFS_MADR1, {16'h0000, rows[i].a1});
      apb(1'b1, OFS_MADR2, {16'h0000, rows[i].a2});
      apb(1'b1, OFS_AMASK, {16'h0000, rows[i].am});
      pulse(0);
      ev(rows[i].kind, rows[i].adr, rows[i].adr, rows[i].ev);
      $display("row %0d done", i);
    end
    // reset in mid-run restores defaults; unmapped offset refused
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, OFS_AMASK, 32'h0);
    chk(rdata, 32'h0000_FFFF);
    apb(1'b0, OFS_DMASK, 32'h0);
    chk(rdata, 32'h0000_0000);
    apb(1'b0, OFS_EXT, 32'h0);
    chk(rdata, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0);
    chk({rdata[30:0], rerr}, 32'h0000_0001);
    $display("reset test done");
    // data word under mask, then probes under mask
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_MADR1, 32'h0000_1234);
    apb(1'b1, OFS_DWORD, 32'h0000_001A);
    apb(1'b1, OFS_DMASK, 32'h0000_FFF0);
    pulse(0);
    ev(0, 16'h1234, 16'h0015, 1'b1);
    pulse(0);
    ev(0, 16'h1234, 16'h0025, 1'b0);
    probe_v <= 8'h9B;
    apb(1'b1, OFS_DMASK, 32'h0000_0000);
    apb(1'b1, OFS_EXT, 32'h0000_A581);
    pulse(0);
    ev(0, 16'h1234, 16'h0000, 1'b1);
    probe_v <= 8'h85;
    repeat (4) @(posedge mclk);
    pulse(0);
    ev(0, 16'h1234, 16'h0000, 1'b0);
    apb(1'b1, OFS_EXT, 32'h0000_0000);
    $display("compare test done");
    // three events, a step with a new address, two delay samples
    apb(1'b1, OFS_EVTCNT, 32'h0000_0003);
    apb(1'b1, OFS_DLYCNT, 32'h0000_0002);
    pulse(0);
    ev(0, 16'h1234, 16'h0000, 1'b1);
    ev(0, 16'h1234, 16'h0000, 1'b1);
    apb(1'b1, OFS_MADR1, 32'h0000_4321);
    pulse(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({17'h0_0000, rdata[14:0]}, 32'h0000_0001);
    ev(0, 16'h4321, 16'h0000, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({29'h0, rdata[29:27]}, 32'h0000_0002);
    pulse(2);
    @(posedge mclk);
    pulse(3);
    halt_is(1'b0);
    pulse(2);
    halt_is(1'b0);
    pulse(3);
    halt_is(1'b1);
    pulse(0);
    halt_is(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({17'h0_0000, rdata[14:0]}, 32'h0000_0003);
    // a rewritten count is reloaded by the next step
    apb(1'b1, OFS_EVTCNT, 32'h0000_0005);
    pulse(1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({17'h0_0000, rdata[14:0]}, 32'h0000_0005);
    $display("count test done");
    stop_test();
  end
endmodule // tb_breakpoint_event_comparator
